// ==== hdl/sir_pkg.sv ====
package sir_pkg;

  // ==========================================================================
  // Link frame: one address byte then one 16-bit data word, MSB first
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } sir_frame_t;

  localparam int FRAME_BITS = 24;

  // ==========================================================================
  // Register addresses on the link
  localparam logic [7:0] ADDR_SAFETY_STATE  = 8'h01;
  localparam logic [7:0] ADDR_WD_REPLY      = 8'h02;
  localparam logic [7:0] ADDR_SAFE_RELEASE  = 8'h03;
  localparam logic [7:0] ADDR_FLAG_TWO      = 8'h04;
  localparam logic [7:0] ADDR_VOLT_STATUS   = 8'h05;
  localparam logic [7:0] ADDR_ADDR_MIRROR   = 8'h06;
  localparam logic [7:0] ADDR_MODE_CTRL     = 8'h07;
  localparam logic [7:0] ADDR_OTP_PROGRAM   = 8'h08;

  // ==========================================================================
  // Key words
  localparam logic [15:0] DEBUG_LEAVE_WORD  = 16'h4000;
  localparam logic [15:0] WD_GOOD_ANSWER    = 16'h5AB2;
  localparam logic [15:0] SAFE_RELEASE_WORD = 16'hB2A5;
  localparam logic [15:0] FLAG_TWO_CLEAR    = 16'h40F1;
  localparam logic [15:0] VOLT_STATUS_CLEAR = 16'h4550;
  localparam logic [15:0] OTP_PROGRAM_WORD  = 16'hA5C3;

  // ==========================================================================
  // Field positions
  localparam int MODE_TEST_POS   = 0;
  localparam int MIRROR_MAIN_LSB = 0;
  localparam int MIRROR_FS_LSB   = 8;
  localparam int FLAG_SUP_UV7    = 0;
  localparam int FLAG_PRE_UVL    = 1;
  localparam int FLAG_SUP_UVL    = 2;
  localparam int FLAG_WAKE_ONE   = 3;
  localparam int FLAG_TWO_W      = 4;

  // ==========================================================================
  // Reset values and limits
  localparam logic [6:0] I2C_DEBUG_MAIN  = 7'h20;
  localparam logic [6:0] I2C_DEBUG_FS    = 7'h21;
  localparam logic [2:0] FAULT_CNT_RESET = 3'h7;
  localparam logic [1:0] OTP_MAX_BURNS   = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 50000000;
  localparam int INIT_TIMEOUT_MS = 256;
  localparam int INIT_TIMEOUT_CYC = INIT_TIMEOUT_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Initialisation phase states
  typedef enum logic [1:0] {
    INIT_OPEN    = 2'b00,
    INIT_CLOSED  = 2'b01,
    INIT_EXPIRED = 2'b10
  } sir_init_t;

endpackage : sir_pkg

// ==== hdl/sir_link_rx.sv ====
`timescale 1ns/1ps
module sir_link_rx (
  input  wire logic               linkClk,
  input  wire logic               reset,
  input  wire logic               linkSelN,
  input  wire logic               linkMosi,
  output sir_pkg::sir_frame_t     frame_ff,
  output logic                    frameTgl_ff
);
  import sir_pkg::*;

  logic [4:0]  bitCnt_ff;
  logic [22:0] shift_ff;
  wire         lastBit = (bitCnt_ff == 5'(FRAME_BITS - 1));
  wire  [4:0]  nxt_bitCnt = lastBit ? 5'h00 : bitCnt_ff + 5'h01;
  wire         frameEnd = !linkSelN && lastBit;

  // ==========================================================================
  // Bit counter, cleared by the frame's own select while it is high
  always_ff @(posedge linkClk or posedge linkSelN) begin
    if (linkSelN) begin
      bitCnt_ff <= 5'h00;
    end else begin
      bitCnt_ff <= nxt_bitCnt;
    end
  end

  // Shift in and hold the whole word at the frame's last bit
  always_ff @(posedge linkClk) begin
    shift_ff <= {shift_ff[21:0], linkMosi};
    if (frameEnd) begin
      frame_ff <= {shift_ff, linkMosi};
    end
  end

  // Frame toggle; link clock may be still, so reset acts at once
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      frameTgl_ff <= 1'b0;
    end else if (frameEnd) begin
      frameTgl_ff <= ~frameTgl_ff;
    end
  end

endmodule : sir_link_rx

// ==== hdl/sir_safety_init.sv ====
`timescale 1ns/1ps
// Functional notes
// - Writing the debug-leave word to the safety state register ends debug mode.
// - Writing the release word, once debug is left, the fault counter is zero and initialisation closed, frees the safe-state output so it is pulled high.
// - Writing the clear word to main flag register two clears its four flags.
// - Writing the clear word to the regulator voltage status clears its flags.
// - With the debug pin high the target addresses are 0x20 main, 0x21 safety.
// - A mirrored address only takes effect once the debug pin has gone low.
// - Outside debug the target addresses come from an adopted mirror, else from the programmed configuration.
// - Configuration programming is allowed three times, each using one slot.
// - A mode switch without the debug pin high is refused and the mode kept.
// - The present user or test mode is always readable.
// - The first good watchdog answer within 256 ms closes initialisation.
// - The fault counter reaches zero after seven good answers in a row, unless initialisation has expired.
// - The safe-state output stays asserted until debug mode has been left.
module sir_safety_init #(
  parameter int INIT_CYCLES = sir_pkg::INIT_TIMEOUT_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          linkClk,
  input  wire logic                          linkSelN,
  input  wire logic                          linkMosi,
  input  wire logic                          debugPin,
  input  wire logic [6:0]                    otpMainAddr,
  input  wire logic [6:0]                    otpFsAddr,
  input  wire logic [sir_pkg::FLAG_TWO_W-1:0] flagTwoSet,
  input  wire logic [3:0]                    voltStatusSet,
  output logic                               safeOutO_ff,
  output logic                               safeOutOe_ff,
  output logic                               debugLeft_ff,
  output logic                               initExpired_ff,
  output logic [2:0]                         faultCount_ff,
  output logic [sir_pkg::FLAG_TWO_W-1:0]     flagTwo_ff,
  output logic [3:0]                         voltStatus_ff,
  output logic [6:0]                         i2cMainAddr_ff,
  output logic [6:0]                         i2cFsAddr_ff,
  output logic                               testMode_ff,
  output logic                               modeRefused_ff,
  output logic                               otpProgram_ff,
  output logic [1:0]                         otpBurnCount_ff
);
  import sir_pkg::*;

  localparam int TW = $clog2(INIT_CYCLES + 1);

  // ==========================================================================
  // Link receiver and frame crossing
  sir_frame_t frameLink;
  logic       frameTglLink;
  logic       tglMeta_ff;
  logic       tglSync_ff;
  logic       tglSeen_ff;

  sir_link_rx u_rx (
    .linkClk     (linkClk),
    .reset       (reset),
    .linkSelN    (linkSelN),
    .linkMosi    (linkMosi),
    .frame_ff    (frameLink),
    .frameTgl_ff (frameTglLink)
  );

  // Toggle synchroniser; the word is stable long before the toggle lands
  always_ff @(posedge clk) begin
    if (reset) begin
      tglMeta_ff <= 1'b0;
      tglSync_ff <= 1'b0;
      tglSeen_ff <= 1'b0;
    end else begin
      tglMeta_ff <= frameTglLink;
      tglSync_ff <= tglMeta_ff;
      tglSeen_ff <= tglSync_ff;
    end
  end
  wire newFrame = tglSync_ff ^ tglSeen_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want,
                               input logic       strobe);
    hit = strobe && (a == want);
  endfunction : hit

  // ==========================================================================
  // Write decode
  wire [15:0] wData      = frameLink.data;
  wire        wrState    = hit(frameLink.addr, ADDR_SAFETY_STATE, newFrame);
  wire        wrReply    = hit(frameLink.addr, ADDR_WD_REPLY, newFrame);
  wire        wrRelease  = hit(frameLink.addr, ADDR_SAFE_RELEASE, newFrame);
  wire        wrFlagTwo  = hit(frameLink.addr, ADDR_FLAG_TWO, newFrame);
  wire        wrVolt     = hit(frameLink.addr, ADDR_VOLT_STATUS, newFrame);
  wire        wrMirror   = hit(frameLink.addr, ADDR_ADDR_MIRROR, newFrame);
  wire        wrMode     = hit(frameLink.addr, ADDR_MODE_CTRL, newFrame);
  wire        wrOtp      = hit(frameLink.addr, ADDR_OTP_PROGRAM, newFrame);
  wire        leaveReq   = wrState && (wData == DEBUG_LEAVE_WORD);
  wire        goodAnswer = wrReply && (wData == WD_GOOD_ANSWER);
  wire        badAnswer  = wrReply && (wData != WD_GOOD_ANSWER);
  wire        releaseReq = wrRelease && (wData == SAFE_RELEASE_WORD);
  wire        flagClr    = wrFlagTwo && (wData == FLAG_TWO_CLEAR);
  wire        voltClr    = wrVolt && (wData == VOLT_STATUS_CLEAR);
  wire        otpReq     = wrOtp && (wData == OTP_PROGRAM_WORD);

  // ==========================================================================
  // Debug pin synchroniser and falling edge
  logic dbgMeta_ff;
  logic dbgSync_ff;
  logic dbgPrev_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      dbgMeta_ff <= 1'b0;
      dbgSync_ff <= 1'b0;
      dbgPrev_ff <= 1'b0;
    end else begin
      dbgMeta_ff <= debugPin;
      dbgSync_ff <= dbgMeta_ff;
      dbgPrev_ff <= dbgSync_ff;
    end
  end
  wire dbgFall = dbgPrev_ff && !dbgSync_ff;

  // ==========================================================================
  // Initialisation phase and fault counter
  sir_init_t     initState_ff;
  sir_init_t     nxt_initState;
  logic [TW-1:0] initTimer_ff;
  wire           timedOut = (initTimer_ff == TW'(INIT_CYCLES - 1));
  wire           answerOk = goodAnswer && (initState_ff != INIT_EXPIRED);

  // First good answer closes, running out of time expires
  always_comb begin
    case (initState_ff)
      INIT_OPEN: begin
        if (goodAnswer) begin
          nxt_initState = INIT_CLOSED;
        end else if (timedOut) begin
          nxt_initState = INIT_EXPIRED;
        end else begin
          nxt_initState = INIT_OPEN;
        end
      end
      INIT_CLOSED:  nxt_initState = INIT_CLOSED;
      INIT_EXPIRED: nxt_initState = INIT_EXPIRED;
      default:      nxt_initState = INIT_OPEN;
    endcase
  end

  wire [2:0] nxt_faultCount =
      (badAnswer && initState_ff == INIT_CLOSED) ? FAULT_CNT_RESET :
      (answerOk && faultCount_ff != 3'h0) ? faultCount_ff - 3'h1 :
      faultCount_ff;

  // Phase, timer and counter registers
  always_ff @(posedge clk) begin
    if (reset) begin
      initState_ff   <= INIT_OPEN;
      initTimer_ff   <= '0;
      initExpired_ff <= 1'b0;
      faultCount_ff  <= FAULT_CNT_RESET;
    end else begin
      initState_ff   <= nxt_initState;
      initTimer_ff   <= (initState_ff == INIT_OPEN) ? initTimer_ff + 1'b1
                                                    : initTimer_ff;
      initExpired_ff <= (nxt_initState == INIT_EXPIRED);
      faultCount_ff  <= nxt_faultCount;
    end
  end

  // ==========================================================================
  // Debug leave and safe-state output
  wire releaseOk = releaseReq && debugLeft_ff && faultCount_ff == 3'h0
                   && initState_ff == INIT_CLOSED;

  // Output is held low until released; a bad answer asserts it again
  always_ff @(posedge clk) begin
    if (reset) begin
      debugLeft_ff <= 1'b0;
      safeOutO_ff  <= 1'b0;
      safeOutOe_ff <= 1'b1;
    end else begin
      debugLeft_ff <= debugLeft_ff | leaveReq;
      safeOutO_ff  <= 1'b0;
      if (nxt_faultCount != 3'h0) begin
        safeOutOe_ff <= 1'b1;
      end else if (releaseOk) begin
        safeOutOe_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      flagTwo_ff    <= '0;
      voltStatus_ff <= 4'h0;
    end else begin
      flagTwo_ff    <= (flagTwo_ff & ~{FLAG_TWO_W{flagClr}})
                       | flagTwoSet;
      voltStatus_ff <= (voltStatus_ff & ~{4{voltClr}})
                       | voltStatusSet;
    end
  end

  // ==========================================================================
  // Target addresses
  logic [13:0] mirror_ff;
  logic        mirrorValid_ff;
  logic        mirrorUsed_ff;

  wire [6:0] nxt_mainAddr = dbgSync_ff    ? I2C_DEBUG_MAIN :
                            mirrorUsed_ff ? mirror_ff[6:0] :
                            otpMainAddr;
  wire [6:0] nxt_fsAddr   = dbgSync_ff    ? I2C_DEBUG_FS :
                            mirrorUsed_ff ? mirror_ff[13:7] :
                            otpFsAddr;

  // Mirror is written in debug, adopted on the pin's falling edge
  always_ff @(posedge clk) begin
    if (reset) begin
      mirror_ff      <= 14'h0000;
      mirrorValid_ff <= 1'b0;
      mirrorUsed_ff  <= 1'b0;
      i2cMainAddr_ff <= I2C_DEBUG_MAIN;
      i2cFsAddr_ff   <= I2C_DEBUG_FS;
    end else begin
      if (wrMirror && dbgSync_ff) begin
        mirror_ff      <= {wData[MIRROR_FS_LSB +: 7],
                           wData[MIRROR_MAIN_LSB +: 7]};
        mirrorValid_ff <= 1'b1;
      end
      if (dbgFall) begin
        mirrorUsed_ff <= mirrorValid_ff;
      end
      i2cMainAddr_ff <= nxt_mainAddr;
      i2cFsAddr_ff   <= nxt_fsAddr;
    end
  end

  // ==========================================================================
  // Mode switch and configuration programming
  always_ff @(posedge clk) begin
    if (reset) begin
      testMode_ff     <= 1'b0;
      modeRefused_ff  <= 1'b0;
      otpProgram_ff   <= 1'b0;
      otpBurnCount_ff <= 2'h0;
    end else begin
      modeRefused_ff <= wrMode && !dbgSync_ff;
      if (wrMode && dbgSync_ff) begin
        testMode_ff <= wData[MODE_TEST_POS];
      end
      otpProgram_ff <= otpReq && (otpBurnCount_ff != OTP_MAX_BURNS);
      if (otpReq && otpBurnCount_ff != OTP_MAX_BURNS) begin
        otpBurnCount_ff <= otpBurnCount_ff + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_debug_leave: assert property (
    leaveReq |=> debugLeft_ff [*3])
    else $error("debug leave not kept");
  a_release_gate: assert property (
    !debugLeft_ff |=> safeOutOe_ff)
    else $error("safe output freed before debug left");
  a_release_take: assert property (
    releaseOk ##1 !reset |-> !safeOutOe_ff && !safeOutO_ff)
    else $error("release word not honoured");
  a_flag_clear: assert property (
    flagClr && flagTwoSet == '0 |=> flagTwo_ff == '0)
    else $error("flag register two not cleared");
  a_volt_clear: assert property (
    voltClr |=> voltStatus_ff == $past(voltStatusSet))
    else $error("voltage status not cleared");
  a_debug_addr: assert property (
    dbgSync_ff |=> i2cMainAddr_ff == 7'h20 && i2cFsAddr_ff == 7'h21)
    else $error("debug target address wrong");
  a_mirror_hold: assert property (
    dbgSync_ff && dbgPrev_ff ##1 dbgSync_ff |-> !$rose(mirrorUsed_ff))
    else $error("mirror adopted while debug pin high");
  a_otp_limit: assert property (
    otpBurnCount_ff == OTP_MAX_BURNS |=> !otpProgram_ff
      && otpBurnCount_ff == OTP_MAX_BURNS)
    else $error("fourth programming pass allowed");
  a_mode_refuse: assert property (
    wrMode && !dbgSync_ff |=> modeRefused_ff && $stable(testMode_ff))
    else $error("mode change not refused");
  a_init_close: assert property (
    initState_ff == INIT_OPEN && goodAnswer |=> initState_ff == INIT_CLOSED)
    else $error("good answer did not close init");
  a_fault_zero: assert property (
    faultCount_ff == 3'h1 && answerOk && !badAnswer |=> faultCount_ff == 3'h0)
    else $error("fault counter missed zero");

endmodule : sir_safety_init

// ==== test/sir_host_model.sv ====
`timescale 1ns/1ps
// ============================================================================
// Host serial sender
module sir_host_model (
  output logic linkClk,
  output logic linkSelN,
  output logic linkMosi
);
  import sir_pkg::*;

  // Idle link: clock still; select rises once to clear the bit count
  initial begin
    linkClk  = 1'b0;
    linkSelN = 1'b0;
    linkMosi = 1'b0;
    #2 linkSelN = 1'b1;
  end

  // One whole frame, MSB first, 12 ns clock only inside the frame
  task automatic send(input logic [7:0] addr, input logic [15:0] data);
    sir_frame_t frm;
    frm.addr = addr;
    frm.data = data;
    #7;
    linkSelN = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      linkMosi = frm[i];
      #6 linkClk = 1'b1;
      #6 linkClk = 1'b0;
    end
    #6 linkSelN = 1'b1;
    linkMosi = ~linkMosi; // Released line shows no stale bit
    #12;
  endtask : send

endmodule : sir_host_model

// ==== test/sir_safety_init_test.sv ====
`timescale 1ns/1ps
module sir_safety_init_test;
  import sir_pkg::*;

  localparam int INIT_SIM   = 400;
  localparam int MAX_CYCLES = 6000;

  logic                  clk;
  logic                  reset;
  logic                  linkClk;
  logic                  linkSelN;
  logic                  linkMosi;
  logic                  debugPin;
  logic [6:0]            otpMainAddr;
  logic [6:0]            otpFsAddr;
  logic [FLAG_TWO_W-1:0] flagTwoSet;
  logic [3:0]            voltStatusSet;
  logic                  safeOutO;
  logic                  safeOutOe;
  logic                  debugLeft;
  logic                  initExpired;
  logic [2:0]            faultCount;
  logic [FLAG_TWO_W-1:0] flagTwo;
  logic [3:0]            voltStatus;
  logic [6:0]            i2cMainAddr;
  logic [6:0]            i2cFsAddr;
  logic                  testMode;
  logic                  modeRefused;
  logic                  otpProgram;
  logic [1:0]            otpBurnCount;
  int                    miscompares = 0;
  int                    numChecks   = 0;
  int                    cycleCount  = 0;
  int                    refusedSeen = 0;
  int                    programSeen = 0;

  // ==========================================================================
  // Design and host
  sir_safety_init #(.INIT_CYCLES(INIT_SIM)) i_sir_safety_init (
    .clk(clk), .reset(reset), .linkClk(linkClk), .linkSelN(linkSelN),
    .linkMosi(linkMosi), .debugPin(debugPin), .otpMainAddr(otpMainAddr),
    .otpFsAddr(otpFsAddr), .flagTwoSet(flagTwoSet),
    .voltStatusSet(voltStatusSet), .safeOutO_ff(safeOutO),
    .safeOutOe_ff(safeOutOe), .debugLeft_ff(debugLeft),
    .initExpired_ff(initExpired), .faultCount_ff(faultCount),
    .flagTwo_ff(flagTwo), .voltStatus_ff(voltStatus),
    .i2cMainAddr_ff(i2cMainAddr), .i2cFsAddr_ff(i2cFsAddr),
    .testMode_ff(testMode), .modeRefused_ff(modeRefused),
    .otpProgram_ff(otpProgram), .otpBurnCount_ff(otpBurnCount)
  );

  sir_host_model i_sir_host_model (
    .linkClk(linkClk),
    .linkSelN(linkSelN),
    .linkMosi(linkMosi)
  );

  // ==========================================================================
  // Clock, pulse counters and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    cycleCount++;
    if (modeRefused === 1'b1) refusedSeen++;
    if (otpProgram === 1'b1) programSeen++;
    if (cycleCount == MAX_CYCLES) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Whole frame, then room for the crossing to land
  task automatic put(input logic [7:0] addr, input logic [15:0] data);
    i_sir_host_model.send(addr, data);
    repeat (8) @(negedge clk);
  endtask : put

  task automatic do_reset(input logic dbg);
    reset = 1'b1;
    debugPin = dbg;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
  endtask : do_reset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Start-up sequence and side paths
  initial begin
    reset = 1'b0;
    debugPin = 1'b1;
    otpMainAddr = 7'h4A;
    otpFsAddr = 7'h4B;
    flagTwoSet = 4'h0;
    voltStatusSet = 4'h0;
    #1; // Rising reset also clears the still link side
    do_reset(1'b1);
    check(safeOutOe, 1'b1);
    check(faultCount, FAULT_CNT_RESET);
    check(i2cMainAddr, I2C_DEBUG_MAIN);
    check(i2cFsAddr, I2C_DEBUG_FS);
    check(testMode, 1'b0);
    put(ADDR_WD_REPLY, WD_GOOD_ANSWER);
    check(faultCount, 3'h6);
    put(ADDR_SAFE_RELEASE, SAFE_RELEASE_WORD);
    check(safeOutOe, 1'b1);
    put(ADDR_MODE_CTRL, 16'h0001);
    check(testMode, 1'b1);
    put(ADDR_ADDR_MIRROR, 16'h3332);
    check(i2cMainAddr, I2C_DEBUG_MAIN);
    put(ADDR_SAFETY_STATE, DEBUG_LEAVE_WORD);
    check(debugLeft, 1'b1);
    for (int n = 5; n >= 0; n--) begin
      put(ADDR_WD_REPLY, WD_GOOD_ANSWER);
      check(faultCount, 16'(n));
    end
    check(initExpired, 1'b0);
    check(safeOutOe, 1'b1);
    put(ADDR_SAFE_RELEASE, SAFE_RELEASE_WORD);
    check(safeOutOe, 1'b0);
    check(safeOutO, 1'b0);
    // Raise every flag for one cycle, then clear each register
    flagTwoSet = 4'hF;
    voltStatusSet = 4'hF;
    @(negedge clk);
    flagTwoSet = 4'h0;
    voltStatusSet = 4'h0;
    @(negedge clk);
    check(flagTwo, 4'hF);
    put(ADDR_FLAG_TWO, FLAG_TWO_CLEAR);
    check(flagTwo, 4'h0);
    check(voltStatus, 4'hF);
    put(ADDR_VOLT_STATUS, VOLT_STATUS_CLEAR);
    check(voltStatus, 4'h0);
    // A wrong answer reasserts the safe output
    put(ADDR_WD_REPLY, 16'h1234);
    check(faultCount, 3'h7);
    check(safeOutOe, 1'b1);
    // Debug pin low adopts the mirrored addresses
    debugPin = 1'b0;
    repeat (8) @(negedge clk);
    check(i2cMainAddr, 7'h32);
    check(i2cFsAddr, 7'h33);
    put(ADDR_MODE_CTRL, 16'h0000);
    check(refusedSeen, 1);
    check(testMode, 1'b1);
    repeat (4) put(ADDR_OTP_PROGRAM, OTP_PROGRAM_WORD);
    check(programSeen, 3);
    check(otpBurnCount, OTP_MAX_BURNS);
    // Normal start with no answer until the phase expires, then a late answer
    do_reset(1'b0);
    check(i2cMainAddr, 7'h4A);
    check(i2cFsAddr, 7'h4B);
    repeat (INIT_SIM) @(negedge clk);
    check(initExpired, 1'b1);
    put(ADDR_WD_REPLY, WD_GOOD_ANSWER);
    check(faultCount, 3'h7);
    stop_test();
  end

endmodule : sir_safety_init_test
